// ===== udi_pkg.sv
//--------------------------------------------------------------------
// Notes on behaviour
//--------------------------------------------------------------------
`default_nettype none
package udi_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_CFG = 8'h10;
   localparam logic [7:0] OFS_USB_STAT = 8'h18;
   localparam logic [7:0] OFS_USB_EN = 8'h14;
   localparam logic [7:0] OFS_DMA_STAT = 8'h50;
   localparam logic [7:0] OFS_DMA_EN = 8'h54;
   localparam logic [7:0] OFS_CLK_CTRL = 8'h58;
   // Mode register fields
   localparam int MODE_GATE_BIT = 3;
   localparam int MODE_CLK_ON_BIT = 7;
   localparam logic [15:0] MODE_RST = 16'h0000;
   // Config register fields
   localparam int CFG_POL_BIT = 0;
   localparam int CFG_LVL_BIT = 1;
   localparam int CFG_CTRL_LSB = 2;
   localparam int CFG_IN_LSB = 4;
   localparam int CFG_OUT_LSB = 6;
   localparam logic [7:0] CFG_RST = 8'h00;
   // USB status bit positions of pipe events
   localparam int USB_CTRL_BIT = 8;
   localparam int USB_IN_BIT = 9;
   localparam int USB_OUT_BIT = 10;
   // Pulse timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_NS = 60;
   localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Pipe generation modes
   typedef enum logic [1:0] {
      PM_ALL = 2'b00,
      PM_ACK = 2'b01,
      PM_NAK = 2'b10,
      PM_OFF = 2'b11
   } udi_pipe_mode_t;
   // Pipe event with its handshake kind
   typedef struct packed {
      logic hit;
      logic nak;
   } udi_pipe_evt_t;
endpackage
`default_nettype wire

// ===== udi_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Fixed-width pulse stretcher, started by a one-cycle trigger
module udi_pulse_gen #(
   parameter int WIDTH = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic trig,
   output logic pulse
);
   logic [7:0] cnt_q, cnt_d;
   //--------------------------------------------------------------
   // Counter
   //--------------------------------------------------------------
   // Load on trigger, count down to zero
   always_comb begin
      cnt_d = cnt_q;
      if (trig) begin
         cnt_d = 8'(WIDTH);
      end else if (cnt_q != 8'h00) begin
         cnt_d = cnt_q - 8'h01;
      end
   end
   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign pulse = (cnt_q != 8'h00);
endmodule
`default_nettype wire

// ===== udi_irq_ctrl.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Interrupt output logic with APB register access
module udi_irq_ctrl #(
   parameter int USB_EVTS = 16,
   parameter int DMA_EVTS = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [USB_EVTS-1:0] usb_evt,
   input wire logic [DMA_EVTS-1:0] dma_evt,
   input wire udi_pkg::udi_pipe_evt_t ctrl_evt,
   input wire udi_pkg::udi_pipe_evt_t in_evt,
   input wire udi_pkg::udi_pipe_evt_t out_evt,
   input wire logic suspend,
   input wire logic vbus,
   output logic clk_wake,
   output logic irq_pin
);
   import udi_pkg::*;

   //--------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------
   // Decide whether a pipe event is reported under a mode
   function automatic logic pipe_pass(input logic [1:0] m, input udi_pipe_evt_t e);
      logic r;
      r = 1'b0;
      case (udi_pipe_mode_t'(m))
         PM_ALL: r = e.hit;
         PM_ACK: r = e.hit & ~e.nak;
         PM_NAK: r = e.hit & e.nak;
         PM_OFF: r = 1'b0;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   //--------------------------------------------------------------
   // Bus decode
   //--------------------------------------------------------------
   logic wr_acc, rd_acc, hit;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;
   // Known addresses
   always_comb begin
      case (paddr)
         OFS_MODE, OFS_CFG, OFS_USB_STAT, OFS_USB_EN,
         OFS_DMA_STAT, OFS_DMA_EN, OFS_CLK_CTRL: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit;

   //--------------------------------------------------------------
   // Control registers
   //--------------------------------------------------------------
   logic [15:0] mode_q, mode_d;
   logic [7:0] cfg_q, cfg_d;
   logic [USB_EVTS-1:0] usb_en_q, usb_en_d;
   logic [DMA_EVTS-1:0] dma_en_q, dma_en_d;
   // Software writes, defaults give active low level mode
   always_comb begin
      mode_d = mode_q;
      cfg_d = cfg_q;
      usb_en_d = usb_en_q;
      dma_en_d = dma_en_q;
      if (wr_acc && paddr == OFS_MODE) mode_d = pwdata[15:0];
      if (wr_acc && paddr == OFS_CFG) cfg_d = pwdata[7:0];
      if (wr_acc && paddr == OFS_USB_EN) usb_en_d = pwdata[USB_EVTS-1:0];
      if (wr_acc && paddr == OFS_DMA_EN) dma_en_d = pwdata[DMA_EVTS-1:0];
   end
   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= MODE_RST;
         cfg_q <= CFG_RST;
         usb_en_q <= '0;
         dma_en_q <= '0;
      end else begin
         mode_q <= mode_d;
         cfg_q <= cfg_d;
         usb_en_q <= usb_en_d;
         dma_en_q <= dma_en_d;
      end
   end
   property p_cfg_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_CFG) |=> (cfg_q == $past(pwdata[7:0]));
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
   property p_mode_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == OFS_MODE) |=> (mode_q == $past(pwdata[15:0]));
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write lost");
   property p_err_hold;
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !hit) |=> ($stable(mode_q) && $stable(cfg_q));
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("unmapped access changed a register");

   logic gate, pol_high, pulse_mode;
   assign gate = mode_q[MODE_GATE_BIT];
   assign pol_high = cfg_q[CFG_POL_BIT];
   assign pulse_mode = cfg_q[CFG_LVL_BIT];

   //--------------------------------------------------------------
   // Status latching
   //--------------------------------------------------------------
   logic [USB_EVTS-1:0] usb_set, usb_st_q, usb_st_d;
   logic [DMA_EVTS-1:0] dma_st_q, dma_st_d;
   // Pipe events enter the USB status through their mode filters
   always_comb begin
      usb_set = usb_evt;
      usb_set[USB_CTRL_BIT] = usb_evt[USB_CTRL_BIT] |
         pipe_pass(cfg_q[CFG_CTRL_LSB +: 2], ctrl_evt);
      usb_set[USB_IN_BIT] = usb_evt[USB_IN_BIT] |
         pipe_pass(cfg_q[CFG_IN_LSB +: 2], in_evt);
      usb_set[USB_OUT_BIT] = usb_evt[USB_OUT_BIT] |
         pipe_pass(cfg_q[CFG_OUT_LSB +: 2], out_evt);
   end
   // Write one to clear, a new event wins over the clear
   always_comb begin
      usb_st_d = usb_st_q;
      dma_st_d = dma_st_q;
      if (wr_acc && paddr == OFS_USB_STAT) usb_st_d = usb_st_q & ~pwdata[USB_EVTS-1:0];
      if (wr_acc && paddr == OFS_DMA_STAT) dma_st_d = dma_st_q & ~pwdata[DMA_EVTS-1:0];
      usb_st_d = usb_st_d | usb_set;
      dma_st_d = dma_st_d | dma_evt;
   end
   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_st_q <= '0;
         dma_st_q <= '0;
      end else begin
         usb_st_q <= usb_st_d;
         dma_st_q <= dma_st_d;
      end
   end
   property p_usb_latch;
      @(posedge pclk) disable iff (!presetn)
      (|usb_set) |=> ((usb_st_q & $past(usb_set)) == $past(usb_set));
   endproperty
   a_usb_latch: assert property (p_usb_latch) else $error("usb event not latched");
   property p_usb_sticky;
      @(posedge pclk) disable iff (!presetn)
      !(wr_acc && paddr == OFS_USB_STAT) |=> ((usb_st_q & $past(usb_st_q)) == $past(usb_st_q));
   endproperty
   a_usb_sticky: assert property (p_usb_sticky) else $error("usb status lost");
   property p_dma_sticky;
      @(posedge pclk) disable iff (!presetn)
      !(wr_acc && paddr == OFS_DMA_STAT) |=> ((dma_st_q & $past(dma_st_q)) == $past(dma_st_q));
   endproperty
   a_dma_sticky: assert property (p_dma_sticky) else $error("dma status lost");
   property p_ctrl_off;
      @(posedge pclk) disable iff (!presetn)
      (cfg_q[CFG_CTRL_LSB +: 2] == PM_OFF && !usb_evt[USB_CTRL_BIT]) |-> !usb_set[USB_CTRL_BIT];
   endproperty
   a_ctrl_off: assert property (p_ctrl_off) else $error("control pipe not muted");
   property p_in_ack;
      @(posedge pclk) disable iff (!presetn)
      (cfg_q[CFG_IN_LSB +: 2] == PM_ACK && in_evt.hit && !in_evt.nak) |-> usb_set[USB_IN_BIT];
   endproperty
   a_in_ack: assert property (p_in_ack) else $error("in pipe ack not reported");
   property p_out_nak;
      @(posedge pclk) disable iff (!presetn)
      (cfg_q[CFG_OUT_LSB +: 2] == PM_NAK && out_evt.hit && !out_evt.nak &&
         !usb_evt[USB_OUT_BIT]) |-> !usb_set[USB_OUT_BIT];
   endproperty
   a_out_nak: assert property (p_out_nak) else $error("out pipe ack not filtered");

   //--------------------------------------------------------------
   // Interrupt pin
   //--------------------------------------------------------------
   logic pend, pend_q, pend_d, held_q, held_d, trig, pulse;
   assign pend = |(usb_st_q & usb_en_q) | |(dma_st_q & dma_en_q);
   // Level hold: asserts on gate, stays until pending clears
   always_comb begin
      held_d = held_q;
      if (!pend) begin
         held_d = 1'b0;
      end else if (gate) begin
         held_d = 1'b1;
      end
      pend_d = pend;
   end
   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         held_q <= held_d;
         pend_q <= pend_d;
      end
   end
   assign trig = pend & ~pend_q & gate;

   udi_pulse_gen #(
      .WIDTH(PULSE_CYC)
   ) i_udi_pulse_gen (
      .pclk(pclk),
      .presetn(presetn),
      .trig(trig),
      .pulse(pulse)
   );

   logic act;
   assign act = pulse_mode ? pulse : (pend & (held_q | gate));
   assign irq_pin = act ~^ pol_high;
   property p_gated_idle;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && !gate && !held_q) |-> (irq_pin == !pol_high);
   endproperty
   a_gated_idle: assert property (p_gated_idle) else $error("gated pin not idle");
   property p_trig_gate;
      @(posedge pclk) disable iff (!presetn)
      (!gate) |-> !trig;
   endproperty
   a_trig_gate: assert property (p_trig_gate) else $error("pulse started while gated");
   property p_one_trig;
      @(posedge pclk) disable iff (!presetn)
      trig |=> !trig;
   endproperty
   a_one_trig: assert property (p_one_trig) else $error("pulse started twice");
   property p_level_pol;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && pol_high && act) |-> irq_pin;
   endproperty
   a_level_pol: assert property (p_level_pol) else $error("active high pin low");
   property p_held_drop;
      @(posedge pclk) disable iff (!presetn)
      (!pend) |=> !held_q;
   endproperty
   a_held_drop: assert property (p_held_drop) else $error("hold kept after clear");

   //--------------------------------------------------------------
   // Clock wake
   //--------------------------------------------------------------
   logic vbus_q, wake_q, wake_d;
   // Wake on any VBUS change while suspended with clock off
   always_comb begin
      wake_d = 1'b0;
      if (suspend && !mode_q[MODE_CLK_ON_BIT] && (vbus != vbus_q)) wake_d = 1'b1;
   end
   // Register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vbus_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         vbus_q <= vbus;
         wake_q <= wake_d;
      end
   end
   assign clk_wake = wake_q;
   property p_wake_off;
      @(posedge pclk) disable iff (!presetn)
      mode_q[MODE_CLK_ON_BIT] |=> !clk_wake;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake with clock kept on");
   property p_wake_edge;
      @(posedge pclk) disable iff (!presetn)
      (suspend && !mode_q[MODE_CLK_ON_BIT] && (vbus != vbus_q)) |=> clk_wake;
   endproperty
   a_wake_edge: assert property (p_wake_edge) else $error("vbus change missed");

   //--------------------------------------------------------------
   // Read data
   //--------------------------------------------------------------
   logic [31:0] rd_d, rd_q;
   // Registered read mux
   always_comb begin
      rd_d = 32'h0000_0000;
      case (paddr)
         OFS_MODE: rd_d[15:0] = mode_q;
         OFS_CFG: rd_d[7:0] = cfg_q;
         OFS_USB_STAT: rd_d[USB_EVTS-1:0] = usb_st_q;
         OFS_USB_EN: rd_d[USB_EVTS-1:0] = usb_en_q;
         OFS_DMA_STAT: rd_d[DMA_EVTS-1:0] = dma_st_q;
         OFS_DMA_EN: rd_d[DMA_EVTS-1:0] = dma_en_q;
         OFS_CLK_CTRL: rd_d[1:0] = {act, wake_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end
   // Register; only updates in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         rd_q <= rd_d;
      end
   end
   assign prdata = rd_acc ? rd_q : 32'h0000_0000;
   property p_rd_idle;
      @(posedge pclk) disable iff (!presetn)
      (!rd_acc) |-> (prdata == 32'h0000_0000);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside access");

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   property p_gate_block;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && !held_q && !gate) |-> (act == 1'b0);
   endproperty
   a_gate_block: assert property (p_gate_block) else $error("pin active while gated");
   property p_reset_pol;
      @(posedge pclk) disable iff (!presetn)
      (!pol_high && !act) |-> irq_pin;
   endproperty
   a_reset_pol: assert property (p_reset_pol) else $error("idle pin not high");
   property p_pulse_width;
      @(posedge pclk) disable iff (!presetn)
      (trig && pulse_mode && !pulse) |=> pulse [*6] ##1 (!pulse || $past(trig, 6));
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
   property p_latch;
      @(posedge pclk) disable iff (!presetn)
      (|dma_evt) |=> ((dma_st_q & $past(dma_evt)) == $past(dma_evt));
   endproperty
   a_latch: assert property (p_latch) else $error("event not latched");
   property p_enable;
      @(posedge pclk) disable iff (!presetn)
      (usb_en_q == '0 && dma_en_q == '0) |-> !pend;
   endproperty
   a_enable: assert property (p_enable) else $error("disabled event pends");
   property p_gate_on;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && pend && gate) |-> act;
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("level pin not asserted");
   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && act && pend && $stable(cfg_q)) |=> (act || !pend);
   endproperty
   a_hold: assert property (p_hold) else $error("pin dropped while pending");
   property p_release;
      @(posedge pclk) disable iff (!presetn)
      (!pulse_mode && !pend) |-> !act;
   endproperty
   a_release: assert property (p_release) else $error("pin stuck after clear");
endmodule
`default_nettype wire

// ===== udi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host firmware stand-in: reset driver and APB master
module udi_host_model #(
   parameter int RST_CYC = 8
) (
   input wire logic pclk,
   output logic presetn,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus, reset held for a shortened span after power-up
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (RST_CYC) @(posedge pclk);
      presetn <= 1'b1;
   end
   // One transfer; always a whole word, so clears cover every byte
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== usb_dev_irq_output_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module usb_dev_irq_output_ctrl_test;
   import udi_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, suspend, vbus, clk_wake, irq_pin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] usb_evt, dma_evt;
   udi_pipe_evt_t ctrl_evt, in_evt, out_evt;
   logic e;
   int failures = 0;
   int n_compared = 0;
   int ki, kw;
   //---------------------------------------------
   // Clock, host and device
   //---------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   udi_host_model i_udi_host_model (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   udi_irq_ctrl i_udi_irq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .usb_evt(usb_evt), .dma_evt(dma_evt),
      .ctrl_evt(ctrl_evt), .in_evt(in_evt), .out_evt(out_evt), .suspend(suspend),
      .vbus(vbus), .clk_wake(clk_wake), .irq_pin(irq_pin));
   //---------------------------------------------
   // Helpers
   //---------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_udi_host_model.xfer(1'b1, a, d, q, e);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      i_udi_host_model.xfer(1'b0, a, 32'h0, q, e);
      #1;
      `CHK("read data", ex, q)
   endtask
   task automatic fire(input logic [15:0] u, input logic [15:0] d);
      @(posedge pclk);
      usb_evt <= u;
      dma_evt <= d;
      @(posedge pclk);
      usb_evt <= 16'h0;
      dma_evt <= 16'h0;
      #1;
   endtask
   task automatic pipe_fire(input int p, input logic n);
      @(posedge pclk);
      if (p == 0) ctrl_evt <= '{hit: 1'b1, nak: n};
      if (p == 1) in_evt <= '{hit: 1'b1, nak: n};
      if (p == 2) out_evt <= '{hit: 1'b1, nak: n};
      @(posedge pclk);
      ctrl_evt <= '0;
      in_evt <= '0;
      out_evt <= '0;
      #1;
   endtask
   // Counts cycles with pin high and with wake high
   task automatic cnt(input int cyc);
      ki = 0;
      kw = 0;
      repeat (cyc) begin
         if (irq_pin === 1'b1) ki++;
         if (clk_wake === 1'b1) kw++;
         @(posedge pclk);
         #1;
      end
   endtask
   //---------------------------------------------
   // Scenarios
   //---------------------------------------------
   task automatic t_reset;
      `CHK("idle pin", 1'b1, irq_pin)
      `CHK("ready", 1'b1, pready)
      rd(OFS_CFG, 32'h0);
      rd(OFS_MODE, 32'h0);
      rd(8'h40, 32'h0);
      `CHK("slverr", 1'b1, e)
   endtask
   task automatic t_level;
      wr(OFS_USB_EN, 32'h1);
      fire(16'h1, 16'h0);
      `CHK("gate off pin", 1'b1, irq_pin)
      wr(OFS_MODE, 32'h8);
      `CHK("gate on pin", 1'b0, irq_pin)
      rd(OFS_CLK_CTRL, 32'h2);
      wr(OFS_MODE, 32'h0);
      `CHK("gate dropped pin", 1'b0, irq_pin)
      fire(16'h2, 16'h0);
      rd(OFS_USB_STAT, 32'h3);
      wr(OFS_USB_STAT, 32'h1);
      `CHK("cleared pin", 1'b1, irq_pin)
      wr(OFS_MODE, 32'h8);
      fire(16'h4, 16'h0);
      `CHK("masked pin", 1'b1, irq_pin)
      wr(OFS_DMA_EN, 32'h1);
      fire(16'h0, 16'h1);
      rd(OFS_DMA_STAT, 32'h1);
      `CHK("dma pin", 1'b0, irq_pin)
      wr(OFS_DMA_STAT, 32'h1);
      `CHK("dma cleared pin", 1'b1, irq_pin)
      wr(OFS_USB_STAT, 32'hFFFF);
      wr(OFS_DMA_EN, 32'h0);
   endtask
   task automatic t_pulse;
      wr(OFS_CFG, 32'h3);
      `CHK("high idle pin", 1'b0, irq_pin)
      fire(16'h1, 16'h0);
      cnt(12);
      `CHK("pulse cycles", PULSE_CYC, ki)
      wr(OFS_USB_STAT, 32'hFFFF);
      wr(OFS_CFG, 32'h0);
   endtask
   task automatic t_pipe;
      logic ex;
      wr(OFS_USB_EN, 32'h700);
      for (int p = 0; p < 3; p++) begin
         for (int m = 0; m < 4; m++) begin
            for (int n = 0; n < 2; n++) begin
               wr(OFS_CFG, 32'(m) << (CFG_CTRL_LSB + 2 * p));
               pipe_fire(p, n[0]);
               ex = (m == 0) || (m == 1 && n == 0) || (m == 2 && n == 1);
               `CHK("pipe pin", !ex, irq_pin)
               wr(OFS_USB_STAT, 32'h700);
            end
         end
      end
      wr(OFS_CFG, 32'h0);
      wr(OFS_MODE, 32'h0);
   endtask
   task automatic t_wake;
      @(posedge pclk);
      suspend <= 1'b1;
      @(posedge pclk);
      vbus <= 1'b1;
      cnt(5);
      `CHK("wake pulses", 1, kw)
      wr(OFS_MODE, 32'h80);
      @(posedge pclk);
      vbus <= 1'b0;
      cnt(5);
      `CHK("wake with clock on", 0, kw)
      @(posedge pclk);
      suspend <= 1'b0;
      wr(OFS_MODE, 32'h0);
   endtask
   //---------------------------------------------
   // Sequence, watchdog and verdict
   //---------------------------------------------
   task automatic test_done;
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      usb_evt = 16'h0;
      dma_evt = 16'h0;
      ctrl_evt = '0;
      in_evt = '0;
      out_evt = '0;
      suspend = 1'b0;
      vbus = 1'b0;
      @(posedge presetn);
      t_reset;
      t_level;
      t_pulse;
      t_pipe;
      t_wake;
      test_done;
   end
   initial begin
      #100000;
      failures++;
      test_done;
   end
endmodule
`default_nettype wire
